// >>> rtl/sss_defines.vh
`ifndef SSS_DEFINES_VH
`define SSS_DEFINES_VH

// Register indices
`define SSS_ADDR_OV_CODE 8'h01
`define SSS_ADDR_UV_CODE 8'h02
`define SSS_ADDR_PRI_TIME 8'h07
`define SSS_ADDR_WAKE_TIME 8'h08
`define SSS_ADDR_RST_TIME 8'h09
`define SSS_ADDR_FAULT 8'h0a

// Field positions
`define SSS_HOLD_LSB 0
`define SSS_DELAY_LSB 3
`define SSS_FAULT_OVER 0
`define SSS_FAULT_UNDER 1
`define SSS_FAULT_WAKE 2

// Reset values
`define SSS_CODE4_RST 4'h0
`define SSS_CODE3_RST 3'h0

// Timing: one time-base tick is 0.01 ms
`define SSS_CLK_PERIOD_NS 50
`define SSS_TICK_NS 10000
`define SSS_TICK_CYCLES (`SSS_TICK_NS / `SSS_CLK_PERIOD_NS)
`define SSS_GLITCH_TICKS 3
`define SSS_WARN_TICKS 10
`define SSS_CNT_W 18

// Channel sequencer states
`define SSS_ST_IDLE 3'h0
`define SSS_ST_GLITCH 3'h1
`define SSS_ST_DELAY 3'h2
`define SSS_ST_ACTIVE 3'h3
`define SSS_ST_HOLD 3'h4

`endif

// >>> rtl/sss_channel.v
`include "sss_defines.vh"
`default_nettype none

module sss_channel #(
  parameter CNT_W = `SSS_CNT_W
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire tick_in,
  input wire fault_in,
  input wire [CNT_W-1:0] glitch_ticks_in,
  input wire [CNT_W-1:0] warn_ticks_in,
  input wire [CNT_W-1:0] delay_ticks_in,
  input wire [CNT_W-1:0] hold_ticks_in,
  output reg warn_out,
  output reg active_out,
  output reg trip_out
);

localparam ST_IDLE = `SSS_ST_IDLE;
localparam ST_GLITCH = `SSS_ST_GLITCH;
localparam ST_DELAY = `SSS_ST_DELAY;
localparam ST_ACTIVE = `SSS_ST_ACTIVE;
localparam ST_HOLD = `SSS_ST_HOLD;

reg [2:0] state_reg;
reg [2:0] state_next;
reg [CNT_W-1:0] cnt_reg;
reg [CNT_W-1:0] cnt_next;
wire [CNT_W-1:0] cnt_inc;

assign cnt_inc = tick_in ? cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_reg;

always @* begin
  state_next = state_reg;
  cnt_next = cnt_inc;
  case (state_reg)
    ST_IDLE: begin
      cnt_next = {CNT_W{1'b0}};
      if (fault_in) begin
        state_next = ST_GLITCH;
      end
    end
    ST_GLITCH: begin
      if (!fault_in) begin
        state_next = ST_IDLE;
      end else if (cnt_inc >= glitch_ticks_in) begin
        state_next = ST_DELAY;
        cnt_next = {CNT_W{1'b0}};
      end
    end
    ST_DELAY: begin
      if (!fault_in) begin
        state_next = ST_IDLE;
      end else if (cnt_inc >= delay_ticks_in) begin
        state_next = ST_ACTIVE;
      end
    end
    ST_ACTIVE: begin
      cnt_next = {CNT_W{1'b0}};
      if (!fault_in) begin
        state_next = ST_HOLD;
      end
    end
    ST_HOLD: begin
      if (fault_in) begin
        state_next = ST_ACTIVE;
        cnt_next = {CNT_W{1'b0}};
      end else if (cnt_inc >= hold_ticks_in) begin
        state_next = ST_IDLE;
      end
    end
    default: begin
      state_next = ST_IDLE;
      cnt_next = {CNT_W{1'b0}};
    end
  endcase
end

always @(posedge core_clk_in) begin
  if (rst_in) begin
    state_reg <= ST_IDLE;
    cnt_reg <= {CNT_W{1'b0}};
    warn_out <= 1'b0;
    active_out <= 1'b0;
    trip_out <= 1'b0;
  end else begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    active_out <= (state_next == ST_ACTIVE) || (state_next == ST_HOLD);
    warn_out <= ((state_next == ST_DELAY) && (cnt_next >= warn_ticks_in))
      || (state_next == ST_ACTIVE) || (state_next == ST_HOLD);
    trip_out <= (state_reg == ST_DELAY) && (state_next == ST_ACTIVE);
  end
end

endmodule // sss_channel

`default_nettype wire

// >>> rtl/sss_supervisor.v
// What this block does
// - Decode every 3-bit timing code into a duration from its table.
// - After reset all timing codes are 000: primary 200 ms hold, 1200 ms delay; wake 10 ms hold, 100 ms delay.
// - Four-bit overvoltage code at 0x01, undervoltage code at 0x02.
// - Keep shutdown low for the hold time after input returns within limits.
// - Delay shutdown assertion until the programmed delay has counted out.
// - Ignore excursions shorter than the glitch rejection interval.
// - Primary faults drive reset with the same delay and hold as shutdown.
// - Record over or under cause in the fault register on shutdown.
// - Warning output goes low before shutdown asserts when the programmed delay exceeds the warning delay, otherwise with it.
// - Warning after its fixed delay; shutdown after programmed delay.
// - High-voltage channels drive shutdown and reset; low rails reset only.
// - Watchdog and manual reset inputs also assert reset.
// - Manual reset overrides every other reset source.
// - After reset, threshold codes select 18.00 V and 8.43 V limits.
// - Default code for both the overvoltage and undervoltage thresholds of the primary channel is 0000.
`include "sss_defines.vh"
`default_nettype none

module sss_supervisor #(
  parameter TICK_CYCLES = `SSS_TICK_CYCLES,
  parameter GLITCH_TICKS = `SSS_GLITCH_TICKS,
  parameter WARN_TICKS = `SSS_WARN_TICKS
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire over_limit_in,
  input wire under_limit_in,
  input wire wake_off_in,
  input wire low_rail_a_fault_in,
  input wire low_rail_b_fault_in,
  input wire watchdog_expired_in,
  input wire manual_reset_n_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rd_valid_out,
  output reg [3:0] over_limit_code_out,
  output reg [3:0] under_limit_code_out,
  output reg [`SSS_CNT_W-1:0] watchdog_timeout_out,
  output reg shutdown_n_out,
  output reg shutdown_warning_n_out,
  output reg reset_n_out
);

localparam CW = `SSS_CNT_W;
localparam integer TICK_LAST_I = TICK_CYCLES - 1;
localparam integer GLITCH_I = GLITCH_TICKS;
localparam integer WARN_I = WARN_TICKS;
localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
localparam [CW-1:0] GLITCH_T = GLITCH_I[CW-1:0];
localparam [CW-1:0] WARN_T = WARN_I[CW-1:0];
localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////
// Timing tables, in 0.01 ms ticks

function [CW-1:0] pri_hold;
  input [2:0] code;
  begin
    case (code)
      3'h0: pri_hold = 18'h4e20;
      3'h1: pri_hold = 18'h3a98;
      3'h2: pri_hold = 18'h2710;
      3'h3: pri_hold = 18'h1f40;
      3'h4: pri_hold = 18'h1770;
      3'h5: pri_hold = 18'h0fa0;
      3'h6: pri_hold = 18'h07d0;
      default: pri_hold = 18'h0007;
    endcase
  end
endfunction

function [CW-1:0] pri_delay;
  input [2:0] code;
  begin
    case (code)
      3'h0: pri_delay = 18'h1_d4c0;
      3'h1: pri_delay = 18'h1_86a0;
      3'h2: pri_delay = 18'h1_3880;
      3'h3: pri_delay = 18'h9c40;
      3'h4: pri_delay = 18'h4e20;
      3'h5: pri_delay = 18'h2710;
      3'h6: pri_delay = 18'h1388;
      default: pri_delay = 18'h0007;
    endcase
  end
endfunction

function [CW-1:0] wake_hold;
  input [2:0] code;
  begin
    case (code)
      3'h0: wake_hold = 18'h03e8;
      3'h1: wake_hold = 18'h07d0;
      3'h2: wake_hold = 18'h0bb8;
      3'h3: wake_hold = 18'h0fa0;
      3'h4: wake_hold = 18'h1388;
      3'h5: wake_hold = 18'h2710;
      3'h6: wake_hold = 18'h4e20;
      default: wake_hold = 18'h0007;
    endcase
  end
endfunction

function [CW-1:0] wake_delay;
  input [2:0] code;
  begin
    case (code)
      3'h0: wake_delay = 18'h2710;
      3'h1: wake_delay = 18'h1388;
      3'h2: wake_delay = 18'h4e20;
      3'h3: wake_delay = 18'h9c40;
      3'h4: wake_delay = 18'h1_3880;
      3'h5: wake_delay = 18'h1_86a0;
      3'h6: wake_delay = 18'h1_d4c0;
      default: wake_delay = 18'h0007;
    endcase
  end
endfunction

function [CW-1:0] rst_hold;
  input [2:0] code;
  begin
    case (code)
      3'h0: rst_hold = 18'h4e20;
      3'h1: rst_hold = 18'h3a98;
      3'h2: rst_hold = 18'h2710;
      3'h3: rst_hold = 18'h1388;
      3'h4: rst_hold = 18'h0bb8;
      3'h5: rst_hold = 18'h05dc;
      3'h6: rst_hold = 18'h0064;
      default: rst_hold = 18'h000a;
    endcase
  end
endfunction

function [CW-1:0] wd_time;
  input [2:0] code;
  begin
    case (code)
      3'h0: wd_time = 18'h2_49f0;
      3'h1: wd_time = 18'h3_0d40;
      3'h2: wd_time = 18'h1_e848;
      3'h3: wd_time = 18'h1_86a0;
      3'h4: wd_time = 18'h1_24f8;
      3'h5: wd_time = 18'hc350;
      3'h6: wd_time = 18'h61a8;
      default: wd_time = 18'h2710;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Registers

reg [5:0] pri_time_reg;
reg [5:0] wake_time_reg;
reg [5:0] rst_time_reg;
reg [2:0] fault_reg;
reg [2:0] fault_next;
reg [7:0] rdata_next;
wire pri_trip;
wire wake_trip;
wire fault_rd;

assign fault_rd = reg_rd_in && (reg_addr_in == `SSS_ADDR_FAULT);

always @* begin
  if (reg_addr_in == `SSS_ADDR_OV_CODE) begin
    rdata_next = {4'h0, over_limit_code_out};
  end else if (reg_addr_in == `SSS_ADDR_UV_CODE) begin
    rdata_next = {4'h0, under_limit_code_out};
  end else if (reg_addr_in == `SSS_ADDR_PRI_TIME) begin
    rdata_next = {2'h0, pri_time_reg};
  end else if (reg_addr_in == `SSS_ADDR_WAKE_TIME) begin
    rdata_next = {2'h0, wake_time_reg};
  end else if (reg_addr_in == `SSS_ADDR_RST_TIME) begin
    rdata_next = {2'h0, rst_time_reg};
  end else if (reg_addr_in == `SSS_ADDR_FAULT) begin
    rdata_next = {5'h00, fault_reg};
  end else begin
    rdata_next = 8'h00;
  end
end

// cause capture, set wins over read clear
always @* begin
  fault_next = fault_rd ? 3'h0 : fault_reg;
  if (pri_trip) begin
    fault_next[`SSS_FAULT_OVER] = fault_next[`SSS_FAULT_OVER] | over_limit_in;
    fault_next[`SSS_FAULT_UNDER] = fault_next[`SSS_FAULT_UNDER]
      | under_limit_in;
  end
  if (wake_trip) begin
    fault_next[`SSS_FAULT_WAKE] = 1'b1;
  end
end

always @(posedge core_clk_in) begin
  if (rst_in) begin
    over_limit_code_out <= `SSS_CODE4_RST;
    under_limit_code_out <= `SSS_CODE4_RST;
    pri_time_reg <= {`SSS_CODE3_RST, `SSS_CODE3_RST};
    wake_time_reg <= {`SSS_CODE3_RST, `SSS_CODE3_RST};
    rst_time_reg <= {`SSS_CODE3_RST, `SSS_CODE3_RST};
    fault_reg <= 3'h0;
    reg_rdata_out <= 8'h00;
    reg_rd_valid_out <= 1'b0;
  end else begin
    fault_reg <= fault_next;
    reg_rd_valid_out <= reg_rd_in;
    if (reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end
    if (reg_wr_in) begin
      if (reg_addr_in == `SSS_ADDR_OV_CODE) begin
        over_limit_code_out <= reg_wdata_in[3:0];
      end else if (reg_addr_in == `SSS_ADDR_UV_CODE) begin
        under_limit_code_out <= reg_wdata_in[3:0];
      end else if (reg_addr_in == `SSS_ADDR_PRI_TIME) begin
        pri_time_reg <= reg_wdata_in[5:0];
      end else if (reg_addr_in == `SSS_ADDR_WAKE_TIME) begin
        wake_time_reg <= reg_wdata_in[5:0];
      end else if (reg_addr_in == `SSS_ADDR_RST_TIME) begin
        rst_time_reg <= reg_wdata_in[5:0];
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Time base and channels

reg [15:0] tick_cnt_reg;
reg tick_reg;
wire pri_fault;
wire pri_warn;
wire pri_active;
wire wake_warn;
wire wake_active;

always @(posedge core_clk_in) begin
  if (rst_in) begin
    tick_cnt_reg <= 16'h0000;
    tick_reg <= 1'b0;
  end else if (tick_cnt_reg == TICK_LAST) begin
    tick_cnt_reg <= 16'h0000;
    tick_reg <= 1'b1;
  end else begin
    tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    tick_reg <= 1'b0;
  end
end

assign pri_fault = over_limit_in | under_limit_in;

sss_channel #(.CNT_W(CW)) u_pri (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .tick_in(tick_reg),
  .fault_in(pri_fault),
  .glitch_ticks_in(GLITCH_T),
  .warn_ticks_in(WARN_T),
  .delay_ticks_in(pri_delay(pri_time_reg[`SSS_DELAY_LSB +: 3])),
  .hold_ticks_in(pri_hold(pri_time_reg[`SSS_HOLD_LSB +: 3])),
  .warn_out(pri_warn),
  .active_out(pri_active),
  .trip_out(pri_trip)
);

sss_channel #(.CNT_W(CW)) u_wake (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .tick_in(tick_reg),
  .fault_in(wake_off_in),
  .glitch_ticks_in(GLITCH_T),
  .warn_ticks_in(WARN_T),
  .delay_ticks_in(wake_delay(wake_time_reg[`SSS_DELAY_LSB +: 3])),
  .hold_ticks_in(wake_hold(wake_time_reg[`SSS_HOLD_LSB +: 3])),
  .warn_out(wake_warn),
  .active_out(wake_active),
  .trip_out(wake_trip)
);

////////////////////////////////////////////////////////////////////////////
// Reset-only sources with reset hold

reg [CW-1:0] rhold_cnt_reg;
reg rail_rst_reg;
wire rail_src;
wire [CW-1:0] rhold_ticks;

// low rails and watchdog reach reset only
assign rail_src = low_rail_a_fault_in | low_rail_b_fault_in
  | watchdog_expired_in;
assign rhold_ticks = rst_hold(rst_time_reg[`SSS_HOLD_LSB +: 3]);

always @(posedge core_clk_in) begin
  if (rst_in) begin
    rhold_cnt_reg <= {CW{1'b0}};
    rail_rst_reg <= 1'b0;
  end else if (rail_src) begin
    rhold_cnt_reg <= {CW{1'b0}};
    rail_rst_reg <= 1'b1;
  end else if (rail_rst_reg && tick_reg) begin
    rhold_cnt_reg <= rhold_cnt_reg + CNT_ONE;
    if (rhold_cnt_reg + CNT_ONE >= rhold_ticks) begin
      rail_rst_reg <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Outputs

always @(posedge core_clk_in) begin
  if (rst_in) begin
    shutdown_n_out <= 1'b1;
    shutdown_warning_n_out <= 1'b1;
    reset_n_out <= 1'b0;
    watchdog_timeout_out <= {CW{1'b0}};
  end else begin
    watchdog_timeout_out <= wd_time(rst_time_reg[`SSS_DELAY_LSB +: 3]);
    shutdown_n_out <= ~(pri_active | wake_active);
    shutdown_warning_n_out <= ~(pri_warn | wake_warn);
    if (!manual_reset_n_in) begin
      reset_n_out <= 1'b0;
    end else begin
      reset_n_out <= ~(pri_active | wake_active | rail_rst_reg);
    end
  end
end

endmodule // sss_supervisor

`default_nettype wire

// >>> testbench/sss_checker.sv
`default_nettype none
module sss_checker (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_rd_in,
  input wire logic over_limit_in,
  input wire logic under_limit_in,
  input wire logic wake_off_in,
  input wire logic low_rail_a_fault_in,
  input wire logic low_rail_b_fault_in,
  input wire logic watchdog_expired_in,
  input wire logic manual_reset_n_in,
  input wire logic reg_rd_valid_out,
  input wire logic shutdown_n_out,
  input wire logic shutdown_warning_n_out,
  input wire logic reset_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire flt;
  assign flt = over_limit_in | under_limit_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_rd_answer: assert property (
    reg_rd_in |=> reg_rd_valid_out) else $error("read not answered");
  a_rd_only: assert property (
    reg_rd_valid_out |-> $past(reg_rd_in)) else $error("stray read valid");
  a_manual_prio: assert property (
    !manual_reset_n_in |=> !reset_n_out) else $error("manual reset ignored");
  a_warn_first: assert property (
    $fell(shutdown_n_out) |-> !$past(shutdown_warning_n_out))
    else $error("shutdown before warning");
  a_reset_follow: assert property (
    $fell(shutdown_n_out) |-> !reset_n_out)
    else $error("reset not with shutdown");
  a_glitch_filter: assert property (
    $fell(shutdown_warning_n_out) |-> ($past(flt, 3) && $past(flt, 6))
    || ($past(wake_off_in, 3) && $past(wake_off_in, 6)))
    else $error("warning on short excursion");
  a_shutdown_n_cause: assert property (
    $fell(shutdown_n_out) |-> $past(flt, 3) || $past(wake_off_in, 3))
    else $error("shutdown without fault");
  a_reset_sources: assert property (
    (low_rail_a_fault_in || low_rail_b_fault_in || watchdog_expired_in)
    |=> ##1 !reset_n_out) else $error("reset source ignored");
  c_trip: cover property ($fell(shutdown_n_out));
  c_read: cover property (reg_rd_valid_out);
  c_manual: cover property (!manual_reset_n_in ##1 !reset_n_out);
endmodule // sss_checker

bind sss_supervisor sss_checker i_chk (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .reg_rd_in(reg_rd_in),
  .over_limit_in(over_limit_in),
  .under_limit_in(under_limit_in),
  .wake_off_in(wake_off_in),
  .low_rail_a_fault_in(low_rail_a_fault_in),
  .low_rail_b_fault_in(low_rail_b_fault_in),
  .watchdog_expired_in(watchdog_expired_in),
  .manual_reset_n_in(manual_reset_n_in),
  .reg_rd_valid_out(reg_rd_valid_out),
  .shutdown_n_out(shutdown_n_out),
  .shutdown_warning_n_out(shutdown_warning_n_out),
  .reset_n_out(reset_n_out)
);
`default_nettype wire

// >>> testbench/sss_supply_model.sv
`default_nettype none
// Supply rail and its two comparators, thresholds in millivolts
module sss_supply_model (
  input wire logic [3:0] ov_code_in,
  input wire logic [3:0] uv_code_in,
  input wire logic [15:0] supply_mv_in,
  output logic over_out,
  output logic under_out
);
  timeunit 1ns;
  timeprecision 1ns;
  function automatic logic [15:0] ov_mv(input logic [3:0] c);
    case (c)
      4'h0: ov_mv = 16'h4650;
      4'h1: ov_mv = 16'h49ac;
      default: ov_mv = 16'h7530;
    endcase
  endfunction
  function automatic logic [15:0] uv_mv(input logic [3:0] c);
    case (c)
      4'h0: uv_mv = 16'h20ee;
      4'h1: uv_mv = 16'h1ef0;
      default: uv_mv = 16'h0000;
    endcase
  endfunction
  // Hysteresis left out: the bench moves the rail well clear of limits
  always_comb begin
    over_out = supply_mv_in > ov_mv(ov_code_in);
    under_out = supply_mv_in < uv_mv(uv_code_in);
  end
endmodule // sss_supply_model
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [15:0] supply_mv = 16'h2ee0;
  logic [2:0] aux_flt = 3'h0;
  logic manual_reset_n_in = 1'b1;
  logic wake_off = 1'b0;
  logic tripped = 1'b0;
  wire over_lim, under_lim, reg_rd_valid_out;
  wire shutdown_n_out, shutdown_warning_n_out, reset_n_out;
  wire [7:0] reg_rdata_out;
  wire [3:0] ov_code, uv_code;
  wire [17:0] wd_time;
  logic [17:0] wdt [8] = '{18'h2_49f0, 18'h3_0d40, 18'h1_e848, 18'h1_86a0,
    18'h1_24f8, 18'hc350, 18'h61a8, 18'h2710};
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int w, s;
  always #25 core_clk_in = ~core_clk_in;
  sss_supervisor #(.TICK_CYCLES(2), .GLITCH_TICKS(3), .WARN_TICKS(2)) i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .over_limit_in(over_lim),
    .under_limit_in(under_lim), .wake_off_in(wake_off),
    .low_rail_a_fault_in(aux_flt[0]), .low_rail_b_fault_in(aux_flt[1]),
    .watchdog_expired_in(aux_flt[2]), .manual_reset_n_in(manual_reset_n_in),
    .reg_rdata_out(reg_rdata_out), .reg_rd_valid_out(reg_rd_valid_out),
    .over_limit_code_out(ov_code), .under_limit_code_out(uv_code),
    .watchdog_timeout_out(wd_time), .shutdown_n_out(shutdown_n_out),
    .shutdown_warning_n_out(shutdown_warning_n_out),
    .reset_n_out(reset_n_out));
  sss_supply_model i_supply (.ov_code_in(ov_code), .uv_code_in(uv_code),
    .supply_mv_in(supply_mv), .over_out(over_lim), .under_out(under_lim));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  always @(negedge core_clk_in) if (shutdown_n_out === 1'b0) tripped = 1'b1;
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk("rd_valid", 1, reg_rd_valid_out);
    chk("rdata", e, reg_rdata_out);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // Drive the rail out of limits, then back; measure warning and shutdown
  task automatic trip(input logic [15:0] mv, input logic [7:0] cause);
    @(posedge core_clk_in);
    supply_mv <= mv;
    w = 0;
    s = 0;
    for (int n = 1; n < 60 && s == 0; n++) begin
      @(negedge core_clk_in);
      if (w == 0 && shutdown_warning_n_out === 1'b0) w = n;
      if (shutdown_n_out === 1'b0) s = n;
    end
    chk("warn_first", 1, w > 0 && w < s);
    chk("warn_time", 1, w >= 6 && w <= 16);
    chk("shutdown_n_delay", 1, s >= 16 && s <= 28);
    chk("rst_follow", 0, reset_n_out);
    rd(8'h0a, cause);
    rd(8'h0a, 8'h00);
    @(posedge core_clk_in);
    supply_mv <= 16'h2ee0;
    s = 0;
    for (int n = 1; n < 60 && s == 0; n++) begin
      @(negedge core_clk_in);
      if (shutdown_n_out === 1'b1) s = n;
    end
    chk("shutdown_n_hold", 1, s >= 12 && s <= 22);
    cycles(2);
    chk("rst_release", 1, reset_n_out);
    chk("warn_release", 1, shutdown_warning_n_out);
  endtask
  task automatic excur(input int n);
    @(posedge core_clk_in);
    supply_mv <= 16'h4a38;
    repeat (n) @(posedge core_clk_in);
    supply_mv <= 16'h2ee0;
    repeat (2) @(posedge core_clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    cycles(3);
    chk("wd_default", 18'h2_49f0, wd_time);
    chk("ov_default", 0, ov_code);
    chk("uv_default", 0, uv_code);
    chk("shutdown_n_idle", 1, shutdown_n_out);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    // Overvoltage limit kept above undervoltage limit
    wr(8'h01, 8'hf1);
    wr(8'h02, 8'h01);
    rd(8'h01, 8'h01);
    rd(8'h02, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(8'h09, {2'b00, i[2:0], 3'b111});
      cycles(2);
      chk("wd_decode", wdt[i], wd_time);
    end
    wr(8'h07, 8'h3f);
    rd(8'h07, 8'h3f);
    trip(16'h4a38, 8'h01);
    trip(16'h1b58, 8'h02);
    tripped = 1'b0;
    excur(2);
    cycles(40);
    chk("glitch_reject", 0, tripped);
    excur(7);
    excur(12);
    cycles(40);
    chk("delay_restart", 0, tripped);
    // Second high-voltage channel with shortest delay and hold
    wr(8'h08, 8'h3f);
    @(posedge core_clk_in);
    wake_off <= 1'b1;
    cycles(30);
    chk("wake_shutdown_n", 0, shutdown_n_out);
    chk("wake_rst", 0, reset_n_out);
    chk("wake_warn", 0, shutdown_warning_n_out);
    rd(8'h0a, 8'h04);
    @(posedge core_clk_in);
    wake_off <= 1'b0;
    cycles(30);
    chk("wake_release", 1, shutdown_n_out);
    chk("wake_rst_rel", 1, reset_n_out);
    @(posedge core_clk_in);
    manual_reset_n_in <= 1'b0;
    cycles(2);
    chk("manual_rst", 0, reset_n_out);
    chk("manual_shutdown_n", 1, shutdown_n_out);
    @(posedge core_clk_in);
    manual_reset_n_in <= 1'b1;
    cycles(40);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_in);
      aux_flt <= 3'h1 << i;
      cycles(3);
      chk("aux_rst", 0, reset_n_out);
      chk("aux_shutdown_n", 1, shutdown_n_out);
      @(posedge core_clk_in);
      aux_flt <= 3'h0;
      cycles(40);
      chk("aux_release", 1, reset_n_out);
    end
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
